// ### design/spdo_map.vh
`ifndef SPDO_MAP_VH
`define SPDO_MAP_VH

// Register indices; the byte address is four times the index.
`define SPDO_IDX_DIV_A 8'h8c
`define SPDO_IDX_DIV_B 8'h8f
`define SPDO_IDX_DIV_C 8'h92
`define SPDO_IDX_DIV_D 8'h98
`define SPDO_IDX_STATUS 8'h9c
`define SPDO_ADDR_DIV_A 12'h230
`define SPDO_ADDR_DIV_B 12'h23c
`define SPDO_ADDR_DIV_C 12'h248
`define SPDO_ADDR_DIV_D 12'h260
`define SPDO_ADDR_STATUS 12'h270

// Reset values.
`define SPDO_RST_DIV_A 24'h000002
`define SPDO_RST_DIV_B 24'h000002
`define SPDO_RST_DIV_C 24'h000032
`define SPDO_RST_DIV_D 24'h000032

// Field positions of a shape-selectable register.
`define SPDO_MODE_HI 23
`define SPDO_MODE_LO 20
`define SPDO_MODE_FRAME 4'hf
`define SPDO_STYLE_BIT 19
`define SPDO_POL_BIT 18
`define SPDO_SEL_HI 17
`define SPDO_SEL_LO 16
`define SPDO_PERIOD_HI 15
`define SPDO_PERIOD_LO 0
`define SPDO_PLAIN_HI 22

// Related-clock selector codes.
`define SPDO_SEL_FIRST 2'h0
`define SPDO_SEL_SECOND 2'h1
`define SPDO_SEL_THIRD 2'h2
`define SPDO_SEL_FOURTH 2'h3

// Smallest ratio a divider honours.
`define SPDO_MIN_RATIO 24'h000002

// AXI responses.
`define SPDO_RESP_OKAY 2'h0
`define SPDO_RESP_SLVERR 2'h2

`endif

// ### design/spdo_div.v
`timescale 1ns/100ps
`include "spdo_map.vh"

module spdo_div (
  input wire aclk,
  input wire aresetn,
  input wire [23:0] ratio,
  output reg clk_o,
  output reg rise_o,
  output reg fall_o
);

  reg [23:0] cnt_r;
  reg [23:0] ratio_r;
  wire [23:0] eff_ratio;
  wire [23:0] high_len;

  // Ratios below two cannot be made from one clock edge per cycle.
  assign eff_ratio = (ratio < `SPDO_MIN_RATIO) ? `SPDO_MIN_RATIO : ratio;
  // Odd ratios spend the spare cycle low, so small odd ratios run short.
  assign high_len = {1'b0, ratio_r[23:1]};

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 24'h000000;
      ratio_r <= `SPDO_MIN_RATIO;
      clk_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (cnt_r >= ratio_r - 24'h000001) begin
        // New ratio only at a period boundary, so no runt periods.
        cnt_r <= 24'h000000;
        ratio_r <= eff_ratio;
        clk_o <= 1'b1;
        rise_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 24'h000001;
        if (cnt_r + 24'h000001 == high_len) begin
          clk_o <= 1'b0;
          fall_o <= 1'b1;
        end
      end
    end
  end

endmodule

// ### design/spdo_frame.v
`timescale 1ns/100ps
`include "spdo_map.vh"

module spdo_frame (
  input wire aclk,
  input wire aresetn,
  input wire rel_rise,
  input wire rel_fall,
  input wire [15:0] period,
  input wire invert,
  input wire edge_style,
  output reg pulse_o
);

  reg [15:0] cnt_r;
  reg active_r;
  wire [15:0] last;

  assign last = (period == 16'h0000) ? 16'h0000 : period - 16'h0001;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 16'h0000;
      active_r <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      if (rel_rise) begin
        cnt_r <= (cnt_r >= last) ? 16'h0000 : cnt_r + 16'h0001;
      end
      if (edge_style) begin
        // Boundary on the leading edge; one related period wide.
        if (rel_rise) begin
          active_r <= (cnt_r >= last);
        end
      end else if (rel_fall) begin
        // Half a related period each side of the boundary.
        if (cnt_r == last) begin
          active_r <= 1'b1;
        end else if (cnt_r == 16'h0000) begin
          active_r <= 1'b0;
        end
      end
      pulse_o <= active_r ^ invert;
    end
  end

endmodule

// ### design/spdo_top.v
`timescale 1ns/100ps
`include "spdo_map.vh"

module spdo_top (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg out_a,
  output reg out_b,
  output reg out_c,
  output reg out_d
);

  reg [23:0] plain_divide_ratio_a_r;
  reg [23:0] plain_divide_ratio_b_r;
  reg [23:0] shaped_c_r;
  reg [23:0] shaped_d_r;
  reg [11:0] awaddr_r;
  reg aw_got_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg w_got_r;

  wire [23:0] ratio_a_value;
  wire [23:0] ratio_b_value;
  wire [23:0] ratio_c_value;
  wire div_a_clk;
  wire div_a_rise;
  wire div_a_fall;
  wire div_b_clk;
  wire div_b_rise;
  wire div_b_fall;
  wire div_c_clk;
  wire div_c_rise;
  wire div_c_fall;
  wire div_d_clk;
  wire div_d_rise;
  wire div_d_fall;
  wire frame_c;
  wire frame_d;
  reg rel_c_rise;
  reg rel_c_fall;
  reg rel_d_rise;
  reg rel_d_fall;
  wire c_sel_ok;
  wire d_sel_ok;

  function [23:0] merge;
    input [23:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge[7:0] = strb[0] ? data[7:0] : old[7:0];
      merge[15:8] = strb[1] ? data[15:8] : old[15:8];
      merge[23:16] = strb[2] ? data[23:16] : old[23:16];
    end
  endfunction

  function is_frame;
    input [23:0] value;
    begin
      is_frame = (value[`SPDO_MODE_HI:`SPDO_MODE_LO] == `SPDO_MODE_FRAME);
    end
  endfunction

  function is_mapped;
    input [11:0] addr;
    begin
      is_mapped = (addr == `SPDO_ADDR_DIV_A) ||
                  (addr == `SPDO_ADDR_DIV_B) ||
                  (addr == `SPDO_ADDR_DIV_C) ||
                  (addr == `SPDO_ADDR_DIV_D) ||
                  (addr == `SPDO_ADDR_STATUS);
    end
  endfunction

  // The top bit of the plain registers is stored but never divides.
  assign ratio_a_value = {1'b0, plain_divide_ratio_a_r[`SPDO_PLAIN_HI:0]};
  assign ratio_b_value = {1'b0, plain_divide_ratio_b_r[`SPDO_PLAIN_HI:0]};
  // Software keeps a normal ratio at or below EFFFFF.
  assign ratio_c_value = shaped_c_r;

  // Write channel: address and data are taken in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPDO_RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      plain_divide_ratio_a_r <= `SPDO_RST_DIV_A;
      plain_divide_ratio_b_r <= `SPDO_RST_DIV_B;
      shaped_c_r <= `SPDO_RST_DIV_C;
      shaped_d_r <= `SPDO_RST_DIV_D;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        awaddr_r <= s_axi_awaddr;
        aw_got_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_got_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(awaddr_r) ? `SPDO_RESP_OKAY :
                       `SPDO_RESP_SLVERR;
        case (awaddr_r)
          `SPDO_ADDR_DIV_A: begin
            plain_divide_ratio_a_r <=
              merge(plain_divide_ratio_a_r, wdata_r, wstrb_r);
          end
          `SPDO_ADDR_DIV_B: begin
            plain_divide_ratio_b_r <=
              merge(plain_divide_ratio_b_r, wdata_r, wstrb_r);
          end
          `SPDO_ADDR_DIV_C: begin
            shaped_c_r <= merge(shaped_c_r, wdata_r, wstrb_r);
          end
          `SPDO_ADDR_DIV_D: begin
            shaped_d_r <= merge(shaped_d_r, wdata_r, wstrb_r);
          end
          default: begin
            shaped_d_r <= shaped_d_r;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: data is captured at the address handshake.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SPDO_RESP_OKAY;
    end else begin
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? `SPDO_RESP_OKAY :
                       `SPDO_RESP_SLVERR;
        case (s_axi_araddr)
          `SPDO_ADDR_DIV_A: s_axi_rdata <= {8'h00, plain_divide_ratio_a_r};
          `SPDO_ADDR_DIV_B: s_axi_rdata <= {8'h00, plain_divide_ratio_b_r};
          `SPDO_ADDR_DIV_C: s_axi_rdata <= {8'h00, shaped_c_r};
          `SPDO_ADDR_DIV_D: s_axi_rdata <= {8'h00, shaped_d_r};
          `SPDO_ADDR_STATUS: begin
            s_axi_rdata <= {26'h0000000, is_frame(shaped_d_r),
                            is_frame(shaped_c_r), out_d, out_c, out_b,
                            out_a};
          end
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  spdo_div u_div_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .ratio(ratio_a_value),
    .clk_o(div_a_clk),
    .rise_o(div_a_rise),
    .fall_o(div_a_fall)
  );

  spdo_div u_div_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .ratio(ratio_b_value),
    .clk_o(div_b_clk),
    .rise_o(div_b_rise),
    .fall_o(div_b_fall)
  );

  spdo_div u_div_c (
    .aclk(aclk),
    .aresetn(aresetn),
    .ratio(ratio_c_value),
    .clk_o(div_c_clk),
    .rise_o(div_c_rise),
    .fall_o(div_c_fall)
  );

  spdo_div u_div_d (
    .aclk(aclk),
    .aresetn(aresetn),
    .ratio(shaped_d_r),
    .clk_o(div_d_clk),
    .rise_o(div_d_rise),
    .fall_o(div_d_fall)
  );

  // Related clocks are sibling dividers. The reserved code gives no ticks,
  // so the pulse would freeze wherever it was; it is parked idle instead.
  assign c_sel_ok =
    (shaped_c_r[`SPDO_SEL_HI:`SPDO_SEL_LO] != `SPDO_SEL_THIRD);
  assign d_sel_ok =
    (shaped_d_r[`SPDO_SEL_HI:`SPDO_SEL_LO] != `SPDO_SEL_FOURTH);
  always @* begin
    case (shaped_c_r[`SPDO_SEL_HI:`SPDO_SEL_LO])
      `SPDO_SEL_FIRST: begin
        rel_c_rise = div_a_rise;
        rel_c_fall = div_a_fall;
      end
      `SPDO_SEL_SECOND: begin
        rel_c_rise = div_b_rise;
        rel_c_fall = div_b_fall;
      end
      `SPDO_SEL_FOURTH: begin
        rel_c_rise = div_d_rise;
        rel_c_fall = div_d_fall;
      end
      default: begin
        rel_c_rise = 1'b0;
        rel_c_fall = 1'b0;
      end
    endcase
    // The output's own divider is the reserved code and gives no ticks.
    case (shaped_d_r[`SPDO_SEL_HI:`SPDO_SEL_LO])
      `SPDO_SEL_FIRST: begin
        rel_d_rise = div_a_rise;
        rel_d_fall = div_a_fall;
      end
      `SPDO_SEL_SECOND: begin
        rel_d_rise = div_b_rise;
        rel_d_fall = div_b_fall;
      end
      `SPDO_SEL_THIRD: begin
        rel_d_rise = div_c_rise;
        rel_d_fall = div_c_fall;
      end
      default: begin
        rel_d_rise = 1'b0;
        rel_d_fall = 1'b0;
      end
    endcase
  end

  spdo_frame u_frame_c (
    .aclk(aclk),
    .aresetn(aresetn),
    .rel_rise(rel_c_rise),
    .rel_fall(rel_c_fall),
    .period(shaped_c_r[`SPDO_PERIOD_HI:`SPDO_PERIOD_LO]),
    .invert(shaped_c_r[`SPDO_POL_BIT]),
    .edge_style(shaped_c_r[`SPDO_STYLE_BIT]),
    .pulse_o(frame_c)
  );

  spdo_frame u_frame_d (
    .aclk(aclk),
    .aresetn(aresetn),
    .rel_rise(rel_d_rise),
    .rel_fall(rel_d_fall),
    .period(shaped_d_r[`SPDO_PERIOD_HI:`SPDO_PERIOD_LO]),
    .invert(shaped_d_r[`SPDO_POL_BIT]),
    .edge_style(shaped_d_r[`SPDO_STYLE_BIT]),
    .pulse_o(frame_d)
  );

  // One more stage keeps every output on a flip-flop.
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_a <= 1'b0;
      out_b <= 1'b0;
      out_c <= 1'b0;
      out_d <= 1'b0;
    end else begin
      out_a <= div_a_clk;
      out_b <= div_b_clk;
      out_c <= !is_frame(shaped_c_r) ? div_c_clk :
               c_sel_ok ? frame_c : shaped_c_r[`SPDO_POL_BIT];
      out_d <= !is_frame(shaped_d_r) ? div_d_clk :
               d_sel_ok ? frame_d : shaped_d_r[`SPDO_POL_BIT];
    end
  end

endmodule

// ### testbench/spdo_checker.sv
`timescale 1ns/100ps
`include "spdo_map.vh"
module spdo_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  wire mapped = s_axi_araddr == `SPDO_ADDR_DIV_A ||
    s_axi_araddr == `SPDO_ADDR_DIV_B || s_axi_araddr == `SPDO_ADDR_DIV_C ||
    s_axi_araddr == `SPDO_ADDR_DIV_D || s_axi_araddr == `SPDO_ADDR_STATUS;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  wr_busy_a: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready [*2]) else $error("address ready too soon");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready))
    else $error("write side not freed");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read side not freed");
  unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && !mapped
    |=> s_axi_rresp == `SPDO_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  mapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && mapped
    |=> s_axi_rresp == `SPDO_RESP_OKAY && s_axi_rdata[31:24] == 8'h0)
    else $error("mapped read refused");
endmodule
bind spdo_top spdo_checker chk (.*);

// ### testbench/testbench.sv
`timescale 1ns/100ps
`include "spdo_map.vh"
module testbench;
  logic aclk = 0;
  logic aresetn = 0;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic [2:0] s_axi_awprot = 3'h0;
  logic s_axi_awvalid = 0;
  wire s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 0;
  wire s_axi_wready;
  wire [1:0] s_axi_bresp;
  wire s_axi_bvalid;
  logic s_axi_bready = 0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_arvalid = 0;
  wire s_axi_arready;
  wire [31:0] s_axi_rdata;
  wire [1:0] s_axi_rresp;
  wire s_axi_rvalid;
  logic s_axi_rready = 0;
  wire out_a, out_b, out_c, out_d;
  wire [3:0] outs = {out_d, out_c, out_b, out_a};
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  spdo_top dut (.*);
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures = failures + 1;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    cmp({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    cmp(s_axi_rdata, exp);
    cmp({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic edge_to(input int i, input logic v);
    while (outs[i] === v) @(posedge aclk);
    while (outs[i] !== v) @(posedge aclk);
  endtask
  // Two edges are skipped since a new ratio waits for a period boundary.
  task automatic measure(input int i, input logic act, input int per,
                         input int wid);
    int t0;
    edge_to(i, act);
    edge_to(i, act);
    t0 = cyc;
    edge_to(i, !act);
    cmp(cyc - t0, wid);
    edge_to(i, act);
    cmp(cyc - t0, per);
  endtask
  task automatic quiet(input int i, input logic lvl);
    repeat (40) @(posedge aclk);
    repeat (20) begin
      @(posedge aclk);
      cmp({31'h0, outs[i]}, {31'h0, lvl});
    end
  endtask
  task automatic t_reset;
    rd(`SPDO_ADDR_DIV_A, 32'h000002, `SPDO_RESP_OKAY);
    rd(`SPDO_ADDR_DIV_B, 32'h000002, `SPDO_RESP_OKAY);
    rd(`SPDO_ADDR_DIV_C, 32'h000032, `SPDO_RESP_OKAY);
    rd(`SPDO_ADDR_DIV_D, 32'h000032, `SPDO_RESP_OKAY);
    rd(12'h004, 32'h0, `SPDO_RESP_SLVERR);
    wr(12'h004, 32'h9, 4'hf, `SPDO_RESP_SLVERR);
    measure(0, 1'b1, 2, 1);
  endtask
  task automatic t_plain;
    wr(`SPDO_ADDR_DIV_A, 32'h000006, 4'hf, `SPDO_RESP_OKAY);
    rd(`SPDO_ADDR_DIV_A, 32'h000006, `SPDO_RESP_OKAY);
    measure(0, 1'b1, 6, 3);
    wr(`SPDO_ADDR_DIV_B, 32'h000005, 4'hf, `SPDO_RESP_OKAY);
    wr(`SPDO_ADDR_DIV_B, 32'h0000ff07, 4'h1, `SPDO_RESP_OKAY);
    rd(`SPDO_ADDR_DIV_B, 32'h000007, `SPDO_RESP_OKAY);
    measure(1, 1'b1, 7, 3);
  endtask
  task automatic t_normal;
    wr(`SPDO_ADDR_DIV_C, 32'h000008, 4'hf, `SPDO_RESP_OKAY);
    measure(2, 1'b1, 8, 4);
    wr(`SPDO_ADDR_DIV_C, 32'h000009, 4'hf, `SPDO_RESP_OKAY);
    measure(2, 1'b1, 9, 4);
  endtask
  // Related clocks: A runs at 6 cycles, B at 7.
  task automatic t_frame;
    wr(`SPDO_ADDR_DIV_C, 32'hf80003, 4'hf, `SPDO_RESP_OKAY);
    rd(`SPDO_ADDR_DIV_C, 32'hf80003, `SPDO_RESP_OKAY);
    measure(2, 1'b1, 18, 6);
    wr(`SPDO_ADDR_DIV_C, 32'hf40003, 4'hf, `SPDO_RESP_OKAY);
    measure(2, 1'b0, 18, 6);
    wr(`SPDO_ADDR_DIV_D, 32'hf10002, 4'hf, `SPDO_RESP_OKAY);
    measure(3, 1'b1, 14, 7);
    wr(`SPDO_ADDR_DIV_C, 32'hf20002, 4'hf, `SPDO_RESP_OKAY);
    quiet(2, 1'b0);
    wr(`SPDO_ADDR_DIV_D, 32'hf70002, 4'hf, `SPDO_RESP_OKAY);
    quiet(3, 1'b1);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_plain;
    t_normal;
    t_frame;
    complete_run;
  end
endmodule
